// file: verilog/lcd_init_command_decoder.v
// Notes on behaviour
// - Block command params 1-2: first block start
// - Params 3 and 6: block line counts
// - Params 4-5: second block start address
// - Params 7-8: third block start address
// - Params 9-10: fourth block start address
// - Pixel shift: three low bits stored
// - Cursor write: low byte, then high
// - Direction command sets direction from code
// - Memory write bytes go to cursor, advance
// - System param 1 loads mode register
// - System params 2-3: character sizes, AC drive
// - System params 4-6: line, total, frame
// - System params 7-8: virtual screen width
// - PLL params 1-2: dividers and multiplier
// - PLL param 3: osc field and multiplier
// - Panel interface param loads enable, polarities
// - Timing params 1-12: six 11-bit values
// - Totals and periods read plus one
// - Sync pulse widths read plus one
// - Line sync position and delay offset
// - Horizontal and vertical scale ratios
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "lcd_init_defines.vh"
module lcd_init_command_decoder (
  // Clock and reset
  input  wire                  clk,
  input  wire                  reset_n,
  input  wire                  ce,
  // AHB-Lite slave
  input  wire                  hsel,
  input  wire [17:0]           haddr,
  input  wire [1:0]            htrans,
  input  wire                  hwrite,
  input  wire [2:0]            hsize,
  input  wire [31:0]           hwdata,
  input  wire                  hready,
  output wire                  hreadyout,
  output wire                  hresp,
  output reg  [31:0]           hrdata,
  // Configuration pins
  input  wire [`STRAP_W-1:0]   config_straps,
  // Decoded panel timing, 12 bits per field, sync widths 9 bits
  output wire [71:0]           panelTiming,
  output reg  [8:0]            frameSyncWidth_q,
  output reg  [8:0]            lineSyncWidth_q,
  // Cursor
  output reg  [15:0]           cursor_q,
  output reg  [1:0]            cursorDir_q
);
  reg  [7:0]  cmd_q;
  reg  [4:0]  paramCnt_q;
  reg  [14:0] virtualWidth_q;
  reg         dataPhase_q;
  reg         dataWrite_q;
  reg  [17:0] dataAddr_q;
  wire [`STRAP_W-1:0] straps;
  wire [7:0]  cfgRd;
  wire [7:0]  dispRd;

  // Address phase
  wire take = hsel & hready & htrans[1] & ce;
  wire cfgSel = haddr[17:9] == `ADDR_CFG_SEL;
  wire dispSel = haddr[17];

  assign hreadyout = ce;
  assign hresp = 1'b0;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dataPhase_q <= 1'b0;
      dataWrite_q <= 1'b0;
      dataAddr_q  <= 18'h00000;
    end else if (ce) begin
      dataPhase_q <= take;
      dataWrite_q <= take & hwrite;
      if (take)
        dataAddr_q <= haddr;
    end
  end

  // Byte written in the data phase
  wire [7:0] wByte = hwdata[7:0];
  wire cmdWr = dataWrite_q & (dataAddr_q == `ADDR_CMD);
  wire parWr = dataWrite_q & (dataAddr_q == `ADDR_DATA);
  wire dirCmd = wByte[7:2] == `CMD_DIR_HI6;
  wire memWr = parWr & (cmd_q == `CMD_MEM_WRITE);

  // Parameter routing table
  reg       pValid;
  reg [6:0] pIndex;
  reg [7:0] pMask;
  always @* begin
    pValid = 1'b0;
    pIndex = `IX_SYSTEM0;
    pMask  = `MASK_ALL;
    case (cmd_q)
      `CMD_SYSTEM: begin
        pValid = paramCnt_q < `NPAR_SYSTEM;
        pIndex = `IX_SYSTEM0 + {2'h0, paramCnt_q};
        if (paramCnt_q == `PAR_SYS_VW_HI)
          pMask = `MASK_HI7;
      end
      `CMD_BLOCKS: begin
        pValid = paramCnt_q < `NPAR_BLOCKS;
        pIndex = `IX_BLOCK0 + {2'h0, paramCnt_q};
        if (paramCnt_q == `PAR_BLK1_HI || paramCnt_q == `PAR_BLK2_HI ||
            paramCnt_q == `PAR_BLK3_HI || paramCnt_q == `PAR_BLK4_HI)
          pMask = `MASK_HI7;
      end
      `CMD_PIX_SHIFT: begin
        pValid = paramCnt_q == 5'h00;
        pIndex = `IX_PIX_SHIFT;
        pMask  = `MASK_SHIFT;
      end
      `CMD_CURSOR_WR: begin
        pValid = paramCnt_q < 5'h02;
        pIndex = `IX_CURSOR_LO + {2'h0, paramCnt_q};
      end
      `CMD_PLL: begin
        pValid = paramCnt_q < `NPAR_PLL;
        pIndex = `IX_PLL0 + {2'h0, paramCnt_q};
        if (paramCnt_q == `PAR_PLL_OSC)
          pMask = `MASK_HI7;
      end
      `CMD_PANEL_IF: begin
        pValid = paramCnt_q == 5'h00;
        pIndex = `IX_PANEL_IF;
      end
      `CMD_PANEL_TIM: begin
        pValid = paramCnt_q < `NPAR_TIMING;
        pIndex = `IX_TIMING0 + {2'h0, paramCnt_q};
        if (paramCnt_q[0] && paramCnt_q != `PAR_LINE_SYNC)
          pMask = `MASK_HI3;
      end
      default: begin
        pValid = 1'b0;
      end
    endcase
  end

  wire cfgWr = (parWr & pValid) | (cmdWr & dirCmd);
  wire [6:0] cfgWrIdx = cmdWr ? `IX_DIR : pIndex;
  wire [7:0] cfgWrData = cmdWr ? (wByte & `MASK_DIR) : (wByte & pMask);
  wire [6:0] wIdx = pIndex;
  wire wParam = parWr & pValid;

  // Command and counter
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_q      <= `CMD_NONE;
      paramCnt_q <= 5'h00;
    end else if (ce) begin
      if (cmdWr) begin
        cmd_q      <= wByte;
        paramCnt_q <= 5'h00;
      end else if (parWr && paramCnt_q != `CNT_MAX) begin
        paramCnt_q <= paramCnt_q + 5'h01;
      end
    end
  end

  // Shadows that steer the cursor
  reg [14:0] step;
  always @* begin
    case (cursorDir_q)
      `DIR_RIGHT: step = 15'h0001;
      `DIR_LEFT:  step = 15'h7FFF;
      `DIR_UP:    step = 15'h0000 - virtualWidth_q;
      default:    step = virtualWidth_q;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cursor_q       <= 16'h0000;
      cursorDir_q    <= `DIR_RIGHT;
      virtualWidth_q <= 15'h0000;
    end else if (ce) begin
      if (cmdWr && dirCmd)
        cursorDir_q <= wByte[1:0];
      if (memWr)
        cursor_q <= {cursor_q[15], cursor_q[14:0] + step};
      if (wParam && wIdx == `IX_CURSOR_LO)
        cursor_q[7:0] <= wByte;
      if (wParam && wIdx == `IX_CURSOR_HI)
        cursor_q[15:8] <= wByte;
      if (wParam && wIdx == `IX_VWIDTH_LO)
        virtualWidth_q[7:0] <= wByte;
      if (wParam && wIdx == `IX_VWIDTH_HI)
        virtualWidth_q[14:8] <= wByte[6:0];
    end
  end

  // Panel timing fields: low at even, high three bits at odd index
  genvar k;
  generate
    for (k = 0; k < 6; k = k + 1) begin : gTiming
      reg  [10:0] raw_q;
      reg  [11:0] out_q;
      localparam [31:0] LO_OFS = 2 * k;
      wire [6:0]  loIdx = `IX_TIMING0 + LO_OFS[6:0];
      wire [5:0]  plusBits = `TIM_PLUS_ONE >> k;
      wire        plus = plusBits[0];
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          raw_q <= 11'h000;
          out_q <= 12'h000;
        end else if (ce) begin
          if (wParam && cmd_q == `CMD_PANEL_TIM && wIdx == loIdx)
            raw_q[7:0] <= wByte;
          if (wParam && cmd_q == `CMD_PANEL_TIM && wIdx == loIdx + 7'h01)
            raw_q[10:8] <= wByte[2:0];
          out_q <= {1'b0, raw_q} + {11'h000, plus};
        end
      end
      assign panelTiming[12*k+11:12*k] = out_q;
    end
  endgenerate

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frameSyncWidth_q <= 9'h000;
      lineSyncWidth_q  <= 9'h000;
    end else if (ce && wParam) begin
      if (wIdx == `IX_FRAME_SYNC)
        frameSyncWidth_q <= {1'b0, wByte} + 9'h001;
      if (wIdx == `IX_LINE_SYNC)
        lineSyncWidth_q <= {1'b0, wByte} + 9'h001;
    end
  end

  // Configuration registers, each parameter byte stored through its field mask
  sync_ram #(
    .AW (`CFG_AW),
    .DW (8)
  ) cfgRam (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (cfgWr),
    .wrAddr (cfgWrIdx),
    .wrData (cfgWrData),
    .rdEn   (take & cfgSel),
    .rdAddr (haddr[8:2]),
    .rdData (cfgRd)
  );

  // Display memory
  sync_ram #(
    .AW (`DISP_AW),
    .DW (8)
  ) dispRam (
    .clk    (clk),
    .ce     (ce),
    .wrEn   (memWr),
    .wrAddr (cursor_q[14:0]),
    .wrData (wByte),
    .rdEn   (take & dispSel),
    .rdAddr (haddr[16:2]),
    .rdData (dispRd)
  );

  strap_capture strapCap (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .strapPins (config_straps),
    .straps_q  (straps)
  );

  // A read taken while the same location is written sees the old ram
  // word, so the written byte is forwarded instead
  reg        cfgFwd_q;
  reg        dispFwd_q;
  reg  [7:0] fwdByte_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfgFwd_q  <= 1'b0;
      dispFwd_q <= 1'b0;
      fwdByte_q <= 8'h00;
    end else if (ce) begin
      cfgFwd_q  <= take & cfgSel & cfgWr & (haddr[8:2] == cfgWrIdx);
      dispFwd_q <= take & dispSel & memWr &
                   (haddr[16:2] == cursor_q[14:0]);
      fwdByte_q <= cfgWr ? cfgWrData : wByte;
    end
  end
  wire [7:0] cfgByte  = cfgFwd_q ? fwdByte_q : cfgRd;
  wire [7:0] dispByte = dispFwd_q ? fwdByte_q : dispRd;

  // Read data; memory windows answer from registered ram output
  always @* begin
    hrdata = 32'h00000000;
    if (dataPhase_q && !dataWrite_q) begin
      if (dataAddr_q[17])
        hrdata = {24'h000000, dispByte};
      else if (dataAddr_q[17:9] == `ADDR_CFG_SEL)
        hrdata = {24'h000000, cfgByte};
      else if (dataAddr_q == `ADDR_CMD)
        hrdata = {16'h0000, cursor_q};
      else if (dataAddr_q == `ADDR_DATA)
        hrdata = {19'h00000, paramCnt_q, cmd_q};
      else if (dataAddr_q == `ADDR_STRAP)
        hrdata = {21'h000000, straps};
    end
  end
endmodule // lcd_init_command_decoder
`default_nettype wire

// file: verilog/lcd_init_defines.vh
`ifndef LCD_INIT_DEFINES_VH
`define LCD_INIT_DEFINES_VH
// Command codes
`define CMD_SYSTEM      8'h40
`define CMD_MEM_WRITE   8'h42
`define CMD_BLOCKS      8'h44
`define CMD_CURSOR_WR   8'h46
`define CMD_DIR_HI6     6'h13
`define CMD_PIX_SHIFT   8'h5A
`define CMD_PLL         8'h62
`define CMD_PANEL_IF    8'h63
`define CMD_PANEL_TIM   8'h64
`define CMD_NONE        8'h00
// Parameter counts per command
`define NPAR_SYSTEM     5'h08
`define NPAR_BLOCKS     5'h0A
`define NPAR_PLL        5'h03
`define NPAR_TIMING     5'h16
`define CNT_MAX         5'h1F
// Register indexes
`define IX_SYSTEM0      7'h00
`define IX_VWIDTH_LO    7'h06
`define IX_VWIDTH_HI    7'h07
`define IX_BLOCK0       7'h0B
`define IX_DIR          7'h17
`define IX_PIX_SHIFT    7'h1B
`define IX_CURSOR_LO    7'h1C
`define IX_CURSOR_HI    7'h1D
`define IX_PLL0         7'h31
`define IX_PANEL_IF     7'h34
`define IX_TIMING0      7'h35
`define IX_FRAME_SYNC   7'h41
`define IX_LINE_SYNC    7'h42
// Parameter positions that carry a narrowed high part, and the frame and line sync width positions
`define PAR_SYS_VW_HI   5'h07
`define PAR_BLK1_HI     5'h01
`define PAR_BLK2_HI     5'h04
`define PAR_BLK3_HI     5'h07
`define PAR_BLK4_HI     5'h09
`define PAR_PLL_OSC     5'h02
`define PAR_FRAME_SYNC  5'h0C
`define PAR_LINE_SYNC   5'h0D
// Field masks
`define MASK_ALL        8'hFF
`define MASK_HI7        8'h7F
`define MASK_HI3        8'h07
`define MASK_DIR        8'h03
`define MASK_SHIFT      8'h07
// Cursor directions
`define DIR_RIGHT       2'h0
`define DIR_LEFT        2'h1
`define DIR_UP          2'h2
// Timing fields read as value plus one (bit per field)
`define TIM_PLUS_ONE    6'h1B
// Bus map
`define ADDR_CMD        18'h00000
`define ADDR_DATA       18'h00004
`define ADDR_STRAP      18'h00008
`define ADDR_CFG_SEL    9'h001
`define HTRANS_NONSEQ   2'h2
// Memory geometry
`define CFG_AW          7
`define DISP_AW         15
`define STRAP_W         11
// Edges after reset release before the strap value is trusted
`define STRAP_SETTLE    2'h2
`endif

// file: verilog/sync_ram.v
`timescale 1ns/10ps
`default_nettype none
module sync_ram #(
  parameter AW = 7,
  parameter DW = 8
) (
  // Clock
  input  wire          clk,
  input  wire          ce,
  // Write port
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [DW-1:0] wrData,
  // Read port
  input  wire          rdEn,
  input  wire [AW-1:0] rdAddr,
  output reg  [DW-1:0] rdData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];

  // No reset on the array: contents undefined until written
  always @(posedge clk) begin
    if (ce) begin
      if (wrEn)
        mem[wrAddr] <= wrData;
      if (rdEn)
        rdData <= mem[rdAddr];
    end
  end
endmodule // sync_ram
`default_nettype wire

// file: verilog/strap_capture.v
`timescale 1ns/10ps
`default_nettype none
`include "lcd_init_defines.vh"
module strap_capture (
  // Clock and reset
  input  wire                    clk,
  input  wire                    reset_n,
  input  wire                    ce,
  // Straps
  input  wire [`STRAP_W-1:0]     strapPins,
  output reg  [`STRAP_W-1:0]     straps_q
);
  reg [`STRAP_W-1:0] meta_q;
  reg [`STRAP_W-1:0] sync_q;
  reg                taken_q;
  reg [1:0]          settle_q;

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q   <= {`STRAP_W{1'b0}};
      sync_q   <= {`STRAP_W{1'b0}};
      straps_q <= {`STRAP_W{1'b0}};
      taken_q  <= 1'b0;
      settle_q <= 2'h0;
    end else if (ce) begin
      meta_q <= strapPins;
      sync_q <= meta_q;
      // Latched once the pins have crossed both flops, then frozen
      if (!taken_q) begin
        if (settle_q == `STRAP_SETTLE) begin
          straps_q <= sync_q;
          taken_q  <= 1'b1;
        end else begin
          settle_q <= settle_q + 2'h1;
        end
      end
    end
  end
endmodule // strap_capture
`default_nettype wire

// file: tb/host_master.sv
`timescale 1ns/10ps
`default_nettype none
module host_master (
  // Clock
  input  wire logic        clk,
  // Answer from the slave
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // Request
  output logic      [17:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [31:0] hwdata
);
  initial begin
    haddr = 18'h00000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
  end

  // Oscillator-clocked host, so no settling pause after a setup code
  // Address 0 carries command codes, address 4 parameters
  task automatic xfer(input logic w, input logic [17:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    // Released lines flip so a stale value cannot pass
    haddr <= ~a;
    hwdata <= w ? d : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    hwdata <= ~d;
  endtask
endmodule // host_master
`default_nettype wire

// file: tb/lcd_init_command_decoder_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_init_command_decoder_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        ce,
  // Bus
  input wire logic        hsel,
  input wire logic [17:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Decoded state
  input wire logic [8:0]  frameSyncWidth_q,
  input wire logic [8:0]  lineSyncWidth_q,
  input wire logic [15:0] cursor_q,
  input wire logic [1:0]  cursorDir_q
);
  logic       cmdPh_q;
  logic       datPh_q;
  logic [7:0] last_q;
  logic [4:0] parCnt_q;
  wire        takeWr = hsel & hready & htrans[1] & ce & hwrite;

  // Phases hold while ce is low, as the bus stalls
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdPh_q <= 1'b0;
      datPh_q <= 1'b0;
      last_q <= 8'h00;
      parCnt_q <= 5'h00;
    end else if (ce) begin
      cmdPh_q <= takeWr & (haddr == 18'h00000);
      datPh_q <= takeWr & (haddr == 18'h00004);
      if (cmdPh_q) begin
        last_q <= hwdata[7:0];
        parCnt_q <= 5'h00;
      end else if (datPh_q && parCnt_q != 5'h1F) begin
        parCnt_q <= parCnt_q + 5'h01;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_HRESP_OKAY:
    assert property (hresp == 1'b0) else $error("error response");
  AST_READY_CE:
    assert property (hreadyout == ce) else $error("hreadyout not ce");
  AST_DIR_CODE:
    assert property (cmdPh_q && ce && hwdata[7:2] == 6'h13 |=>
      cursorDir_q == $past(hwdata[1:0])) else $error("direction wrong");
  AST_DIR_HOLD:
    assert property (datPh_q && ce |=> $stable(cursorDir_q))
      else $error("parameter moved direction");
  AST_CMD_CURSOR:
    assert property (cmdPh_q |=> $stable(cursor_q))
      else $error("command moved cursor");
  AST_MEM_RIGHT:
    assert property (datPh_q && ce && last_q == 8'h42 && cursorDir_q == 2'h0
      |=> cursor_q[14:0] == $past(cursor_q[14:0]) + 15'h0001)
      else $error("cursor not advanced");
  AST_MEM_LEFT:
    assert property (datPh_q && ce && last_q == 8'h42 && cursorDir_q == 2'h1
      |=> cursor_q[14:0] == $past(cursor_q[14:0]) - 15'h0001)
      else $error("cursor not moved back");
  AST_FSYNC_PLUS:
    assert property (datPh_q && ce && last_q == 8'h64 && parCnt_q == 5'h0C
      |=> frameSyncWidth_q == {1'b0, $past(hwdata[7:0])} + 9'h001)
      else $error("frame width not value plus one");
  AST_LSYNC_PLUS:
    assert property (datPh_q && ce && last_q == 8'h64 && parCnt_q == 5'h0D
      |=> lineSyncWidth_q == {1'b0, $past(hwdata[7:0])} + 9'h001)
      else $error("line width not value plus one");
endmodule // lcd_init_command_decoder_assertions

bind lcd_init_command_decoder lcd_init_command_decoder_assertions
  u_lcd_init_command_decoder_assertions (.clk, .reset_n, .ce, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .frameSyncWidth_q,
  .lineSyncWidth_q, .cursor_q, .cursorDir_q);
`default_nettype wire

// file: tb/lcd_init_command_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lcd_init_command_decoder_tb;
  logic        clk;
  logic        reset_n;
  logic        ce;
  logic [10:0] straps;
  logic [31:0] rd;
  wire  [17:0] haddr;
  wire  [1:0]  htrans;
  wire         hwrite;
  wire  [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire  [71:0] panelTiming;
  wire  [8:0]  fsw;
  wire  [8:0]  lsw;
  wire  [15:0] cursor;
  wire  [1:0]  dir;
  int          errors;
  int          checks;

  lcd_init_command_decoder u_lcd_init_command_decoder (.clk(clk),
    .reset_n(reset_n), .ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .config_straps(straps), .panelTiming(panelTiming),
    .frameSyncWidth_q(fsw), .lineSyncWidth_q(lsw), .cursor_q(cursor),
    .cursorDir_q(dir));
  host_master u_host_master (.clk(clk), .hready(hreadyout), .hrdata(hrdata),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmd(input logic [7:0] c);
    u_host_master.xfer(1'b1, 18'h00000, {24'h000000, c}, rd);
  endtask
  task par(input logic [7:0] p);
    u_host_master.xfer(1'b1, 18'h00004, {24'h000000, p}, rd);
  endtask
  task rdw(input logic [17:0] a, input logic [31:0] e, input string n);
    u_host_master.xfer(1'b0, a, 32'h00000000, rd);
    chk(n, e, rd);
  endtask
  task reg_is(input logic [6:0] i, input logic [7:0] e);
    rdw(18'h00200 + {9'h000, i, 2'h0}, {24'h000000, e}, "config register");
  endtask

  task automatic t_system;
    logic [7:0] p [8] = '{8'h38, 8'h87, 8'h07, 8'h3F, 8'h59, 8'h7F, 8'h80,
                          8'hFF};
    cmd(8'h40);
    foreach (p[i]) par(p[i]);
    for (int i = 0; i < 7; i++) reg_is(7'(i), p[i]);
    reg_is(7'h07, 8'h7F);
  endtask

  task t_blocks;
    cmd(8'h44);
    par(8'h11);
    par(8'h22);
    // Fresh code mid-sequence must restart routing at the first slot
    cmd(8'h44);
    rdw(18'h00004, 32'h00000044, "count and code");
    for (logic [7:0] i = 8'h00; i < 8'h0A; i++) par(8'hC0 + i);
    for (logic [7:0] i = 8'h00; i < 8'h0A; i++)
      reg_is(7'h0B + i[6:0], (i == 1 || i == 4 || i == 7 || i == 9) ?
        8'h40 + i : 8'hC0 + i);
  endtask

  task t_short;
    cmd(8'h62);
    par(8'h21);
    par(8'h99);
    par(8'hFF);
    reg_is(7'h31, 8'h21);
    reg_is(7'h32, 8'h99);
    reg_is(7'h33, 8'h7F);
    cmd(8'h63);
    par(8'h25);
    reg_is(7'h34, 8'h25);
    rdw(18'h00008, {21'h0, 11'h5A3}, "straps");
  endtask

  task automatic t_timing;
    logic [11:0] e;
    cmd(8'h64);
    for (logic [7:0] i = 8'h00; i < 8'h16; i++) par(i[0] ? 8'hFF : 8'h30 + i);
    for (logic [7:0] i = 8'h00; i < 8'h16; i++)
      reg_is(7'h35 + i[6:0], (i[0] && i != 13) ? 8'h07 :
        (i[0] ? 8'hFF : 8'h30 + i));
    for (logic [7:0] k = 8'h00; k < 8'h06; k++) begin
      e = {4'h7, 8'h30 + {k[6:0], 1'b0}};
      if (k != 2 && k != 5) e = e + 12'h001;
      chk("panel timing", {20'h00000, e}, {20'h00000, panelTiming[12*k+:12]});
    end
    chk("frame sync width", 32'h0000003D, {23'h0, fsw});
    chk("line sync width", 32'h00000100, {23'h0, lsw});
  endtask

  task automatic t_cursor;
    logic [7:0] m [4] = '{8'hAA, 8'hBB, 8'hCC, 8'hDD};
    cmd(8'h46);
    par(8'h00);
    par(8'h10);
    // Cursor settles only after the closing edge
    @(negedge clk);
    chk("cursor", 32'h00001000, {16'h0000, cursor});
    reg_is(7'h1D, 8'h10);
    for (logic [7:0] c = 8'h4F; c >= 8'h4C; c--) begin
      cmd(c);
      reg_is(7'h17, {6'h00, c[1:0]});
    end
    cmd(8'h42);
    for (int i = 0; i < 3; i++) par(m[i]);
    @(negedge clk);
    chk("cursor", 32'h00001003, {16'h0000, cursor});
    cmd(8'h4D);
    cmd(8'h42);
    par(m[3]);
    rdw(18'h00000, 32'h00001002, "cursor read");
    for (int i = 0; i < 4; i++)
      rdw(18'h20000 + 18'h04000 + 18'(4 * i), {24'h0, m[i]}, "memory");
    // Down then up by the virtual width 7F80h from t_system
    cmd(8'h4F);
    cmd(8'h42);
    par(8'h5E);
    @(negedge clk);
    chk("cursor", 32'h00000F82, {16'h0000, cursor});
    cmd(8'h4E);
    cmd(8'h42);
    par(8'h5F);
    @(negedge clk);
    chk("cursor", 32'h00001002, {16'h0000, cursor});
    rdw(18'h24008, 32'h0000005E, "memory");
    rdw(18'h23E08, 32'h0000005F, "memory");
  endtask

  task t_stall;
    cmd(8'h5A);
    @(posedge clk);
    ce <= 1'b0;
    fork
      par(8'hFF);
      begin
        repeat (3) @(posedge clk);
        chk("hreadyout", 32'h0, {31'h0, hreadyout});
        ce <= 1'b1;
      end
    join
    reg_is(7'h1B, 8'h07);
  endtask

  task give_verdict;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    straps = 11'h5A3;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    t_system();
    t_blocks();
    t_short();
    t_timing();
    t_cursor();
    t_stall();
    give_verdict();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict();
  end
endmodule // lcd_init_command_decoder_tb
`default_nettype wire
